// [shared/led_ctrl_pkg.sv]
// Constants and types for the PHY LED indicator control block
// Operation
// - Sense each LED pin drive polarity at reset
// - Drive LEDs at sensed level per config
// - Keep sensed polarity until next reset
// - Second pin sourcing clears duplex preset
// - Second pin sinking sets duplex preset
// - No LED on second pin: preset undefined
// - Each pin has own 4-bit config field
// - Stretch times 40, 70, 140 ms
// - Code 1110 duplex plus collisions, always stretched
// - Code 1101 link plus tx/rx, always stretched
// - Code 1100 link plus rx, always stretched
// - Codes 1011 slow, 1010 fast, 1001 off, 1000 on
// - Code 0111 tx and rx, stretch if enabled
// - Code 0101 duplex, code 0100 link
// - Code 0011 collisions, stretch if enabled
// - Second field bits 7-4, same codes
// - Code 0010 rx, 0001 tx; 0000 reserved
// - Stretch select 00 normal, 01 medium, 10 long
package led_ctrl_pkg;

  // Register map
  localparam int          REG_ADDR_W       = 4;
  localparam logic [3:0]  LED_CONTROL_ADDR = 4'h0;
  localparam logic [15:0] LED_CONTROL_RST  = 16'h0422;

  // Field positions
  localparam int FIRST_CFG_LSB  = 8;
  localparam int SECOND_CFG_LSB = 4;
  localparam int TIME_SEL_LSB   = 2;
  localparam int STRETCH_EN_BIT = 1;

  // Configuration codes
  localparam logic [3:0] CFG_DUP_COL   = 4'he;
  localparam logic [3:0] CFG_LINK_TXRX = 4'hd;
  localparam logic [3:0] CFG_LINK_RX   = 4'hc;
  localparam logic [3:0] CFG_BLINK_SLO = 4'hb;
  localparam logic [3:0] CFG_BLINK_FST = 4'ha;
  localparam logic [3:0] CFG_OFF       = 4'h9;
  localparam logic [3:0] CFG_ON        = 4'h8;
  localparam logic [3:0] CFG_TXRX      = 4'h7;
  localparam logic [3:0] CFG_DUPLEX    = 4'h5;
  localparam logic [3:0] CFG_LINK      = 4'h4;
  localparam logic [3:0] CFG_COL       = 4'h3;
  localparam logic [3:0] CFG_RX        = 4'h2;
  localparam logic [3:0] CFG_TX        = 4'h1;

  // Stretch time select codes
  localparam logic [1:0] TSEL_MEDIUM = 2'h1;
  localparam logic [1:0] TSEL_LONG   = 2'h2;

  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int NS_PER_MS     = 1000000;
  localparam int CYCLES_PER_MS = NS_PER_MS / CLK_PERIOD_NS;
  localparam int NORMAL_STRETCH_MS = 40;
  localparam int MEDIUM_STRETCH_MS = 70;
  localparam int LONG_STRETCH_MS   = 140;
  localparam int BLINK_SLOW_MS     = 500;
  localparam int BLINK_FAST_MS     = 100;
  localparam int NORMAL_STRETCH_CYCLES = NORMAL_STRETCH_MS * CYCLES_PER_MS;
  localparam int MEDIUM_STRETCH_CYCLES = MEDIUM_STRETCH_MS * CYCLES_PER_MS;
  localparam int LONG_STRETCH_CYCLES   = LONG_STRETCH_MS * CYCLES_PER_MS;
  localparam int BLINK_SLOW_CYCLES     = BLINK_SLOW_MS * CYCLES_PER_MS;
  localparam int BLINK_FAST_CYCLES     = BLINK_FAST_MS * CYCLES_PER_MS;
  localparam logic [7:0] SENSE_CYCLES  = 8'h08;

  // Sequencer phases
  typedef enum logic {PH_SENSE, PH_RUN} phase_t;

endpackage

// [logic/phy_led_indicator_control.sv]
// PHY LED indicator control: polarity sensing, display select, stretching
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/10ps
module phy_led_indicator_control
  import led_ctrl_pkg::*;
#(
  parameter int NORMAL_CYCLES = NORMAL_STRETCH_CYCLES,
  parameter int MEDIUM_CYCLES = MEDIUM_STRETCH_CYCLES,
  parameter int LONG_CYCLES   = LONG_STRETCH_CYCLES,
  parameter int SLOW_CYCLES   = BLINK_SLOW_CYCLES,
  parameter int FAST_CYCLES   = BLINK_FAST_CYCLES
) (
  // Clock and reset
  input  wire logic                  REF_CLK,
  input  wire logic                  SYS_RST,
  // Register port
  input  wire logic [REG_ADDR_W-1:0] REG_ADDR,
  input  wire logic [15:0]           REG_WDATA,
  input  wire logic                  REG_WR,
  input  wire logic                  REG_RD,
  output logic      [15:0]           REG_RDATA,
  // PHY status, same clock
  input  wire logic                  LINK_UP,
  input  wire logic                  DUPLEX_FULL,
  input  wire logic                  TX_ACTIVE,
  input  wire logic                  RX_ACTIVE,
  input  wire logic                  COLLISION,
  // Duplex mode preset
  output logic                       DUPLEX_PRESET,
  output logic                       DUPLEX_PRESET_VALID,
  // First LED pin
  input  wire logic                  FIRST_LED_IN,
  output logic                       FIRST_LED_OUT,
  output logic                       FIRST_LED_OE,
  // Second LED pin
  input  wire logic                  SECOND_LED_IN,
  output logic                       SECOND_LED_OUT,
  output logic                       SECOND_LED_OE
);

  ////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    logic [1:0]       pin_meta;
    logic [1:0]       pin_sync;
    phase_t           phase;
    logic [7:0]       sense_cnt;
    logic [1:0]       active_high;
    logic             duplex_preset;
    logic             preset_valid;
    logic [3:0]       first_led_config;
    logic [3:0]       second_led_config;
    logic [1:0]       stretch_time_select;
    logic             stretch_enable;
    logic [1:0][31:0] stretch_cnt;
    logic [31:0]      slow_cnt;
    logic [31:0]      fast_cnt;
    logic             blink_slow;
    logic             blink_fast;
    logic [1:0]       led_out;
    logic [1:0]       led_oe;
    logic [15:0]      rdata;
  } state_t;

  state_t cur;
  state_t nxt;

  ////////////////////////////////////////////////////////////////////////
  // Decoding shared by both pins

  // Raw activity event selected by a code
  function automatic logic code_event(input logic [3:0] code,
                                      input logic tx, input logic rx,
                                      input logic col);
    case (code)
      CFG_DUP_COL, CFG_COL:    code_event = col;
      CFG_LINK_TXRX, CFG_TXRX: code_event = tx | rx;
      CFG_LINK_RX, CFG_RX:     code_event = rx;
      CFG_TX:                  code_event = tx;
      default:                 code_event = 1'b0;
    endcase
  endfunction

  // Codes stretched whatever the enable says
  function automatic logic code_forced(input logic [3:0] code);
    case (code)
      CFG_DUP_COL, CFG_LINK_TXRX, CFG_LINK_RX: code_forced = 1'b1;
      default:                                 code_forced = 1'b0;
    endcase
  endfunction

  // Logical LED state for a code, before polarity
  function automatic logic code_level(input logic [3:0] code,
                                      input logic link, input logic dup,
                                      input logic act, input logic bs,
                                      input logic bf);
    case (code)
      CFG_DUP_COL:   code_level = dup | act;
      CFG_LINK_TXRX: code_level = link ^ act;
      CFG_LINK_RX:   code_level = link ^ act;
      CFG_BLINK_SLO: code_level = bs;
      CFG_BLINK_FST: code_level = bf;
      CFG_OFF:       code_level = 1'b0;
      CFG_ON:        code_level = 1'b1;
      CFG_TXRX:      code_level = act;
      CFG_DUPLEX:    code_level = dup;
      CFG_LINK:      code_level = link;
      CFG_COL:       code_level = act;
      CFG_RX:        code_level = act;
      CFG_TX:        code_level = act;
      default:       code_level = 1'b0;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic [1:0][3:0] cfg;
    logic [31:0]     load;
    logic            ev;
    logic            str;
    logic            act;
    logic            lvl;
    cfg  = '0;
    load = '0;
    ev   = 1'b0;
    str  = 1'b0;
    act  = 1'b0;
    lvl  = 1'b0;
    nxt  = cur;

    // Pin synchronisers
    nxt.pin_meta = {SECOND_LED_IN, FIRST_LED_IN};
    nxt.pin_sync = cur.pin_meta;

    // Polarity sensing with drivers released
    if (cur.phase == PH_SENSE) begin
      nxt.led_oe  = 2'b00;
      nxt.led_out = 2'b00;
      if (cur.sense_cnt == SENSE_CYCLES) begin
        // Idle low means the pin must source current
        nxt.active_high   = ~cur.pin_sync;
        nxt.duplex_preset = cur.pin_sync[1];
        nxt.preset_valid  = 1'b1;
        nxt.phase         = PH_RUN;
      end else begin
        nxt.sense_cnt = cur.sense_cnt + 8'h01;
      end
    end

    // Register write; reserved bits are not stored
    if (REG_WR && REG_ADDR == LED_CONTROL_ADDR) begin
      nxt.first_led_config    = REG_WDATA[FIRST_CFG_LSB +: 4];
      nxt.second_led_config   = REG_WDATA[SECOND_CFG_LSB +: 4];
      nxt.stretch_time_select = REG_WDATA[TIME_SEL_LSB +: 2];
      nxt.stretch_enable      = REG_WDATA[STRETCH_EN_BIT];
    end

    // Register read, data only in the following cycle
    nxt.rdata = '0;
    if (REG_RD && REG_ADDR == LED_CONTROL_ADDR) begin
      nxt.rdata[FIRST_CFG_LSB +: 4]  = cur.first_led_config;
      nxt.rdata[SECOND_CFG_LSB +: 4] = cur.second_led_config;
      nxt.rdata[TIME_SEL_LSB +: 2]   = cur.stretch_time_select;
      nxt.rdata[STRETCH_EN_BIT]      = cur.stretch_enable;
    end

    // Blink generators
    if (cur.slow_cnt >= 32'(SLOW_CYCLES - 1)) begin
      nxt.slow_cnt   = '0;
      nxt.blink_slow = ~cur.blink_slow;
    end else begin
      nxt.slow_cnt = cur.slow_cnt + 32'h1;
    end
    if (cur.fast_cnt >= 32'(FAST_CYCLES - 1)) begin
      nxt.fast_cnt   = '0;
      nxt.blink_fast = ~cur.blink_fast;
    end else begin
      nxt.fast_cnt = cur.fast_cnt + 32'h1;
    end

    // Selected stretch length; reserved select falls back to normal
    case (cur.stretch_time_select)
      TSEL_MEDIUM: load = 32'(MEDIUM_CYCLES - 1);
      TSEL_LONG:   load = 32'(LONG_CYCLES - 1);
      default:     load = 32'(NORMAL_CYCLES - 1);
    endcase

    // Per pin event stretching and drive
    cfg[0] = cur.first_led_config;
    cfg[1] = cur.second_led_config;
    for (int i = 0; i < 2; i++) begin
      ev  = code_event(cfg[i], TX_ACTIVE, RX_ACTIVE, COLLISION);
      str = code_forced(cfg[i]) | cur.stretch_enable;
      if (!str) begin
        nxt.stretch_cnt[i] = '0;
      end else if (ev) begin
        nxt.stretch_cnt[i] = load;
      end else if (cur.stretch_cnt[i] != 32'h0) begin
        nxt.stretch_cnt[i] = cur.stretch_cnt[i] - 32'h1;
      end
      act = ev | (str && cur.stretch_cnt[i] != 32'h0);
      lvl = code_level(cfg[i], LINK_UP, DUPLEX_FULL, act,
                       cur.blink_slow, cur.blink_fast);
      if (cur.phase == PH_RUN) begin
        nxt.led_oe[i]  = 1'b1;
        nxt.led_out[i] = cur.active_high[i] ? lvl : ~lvl;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge REF_CLK) begin
    if (SYS_RST) begin
      cur                     <= '0;
      cur.phase               <= PH_SENSE;
      cur.first_led_config    <= LED_CONTROL_RST[FIRST_CFG_LSB +: 4];
      cur.second_led_config   <= LED_CONTROL_RST[SECOND_CFG_LSB +: 4];
      cur.stretch_time_select <= LED_CONTROL_RST[TIME_SEL_LSB +: 2];
      cur.stretch_enable      <= LED_CONTROL_RST[STRETCH_EN_BIT];
    end else begin
      cur <= nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs

  assign REG_RDATA           = cur.rdata;
  assign DUPLEX_PRESET       = cur.duplex_preset;
  assign DUPLEX_PRESET_VALID = cur.preset_valid;
  assign FIRST_LED_OUT       = cur.led_out[0];
  assign FIRST_LED_OE        = cur.led_oe[0];
  assign SECOND_LED_OUT      = cur.led_out[1];
  assign SECOND_LED_OE       = cur.led_oe[1];

endmodule

// [testbench/led_partner.sv]
// Discrete LED on one indicator pin, wired to sink or source
`timescale 1ns/10ps
module led_partner (
  // Pin side and wiring choice
  input  wire logic drive,
  input  wire logic oe,
  input  wire logic sink,
  output logic      pin,
  output logic      lit
);
  // A released pin is pulled to the supply side of the LED
  assign pin = oe ? drive : sink;
  // Lit while the driven level pushes current through the LED
  assign lit = oe && (drive != sink);
endmodule

// [testbench/led_ctrl_monitor.sv]
// Port checker for the LED indicator block
`timescale 1ns/10ps
module led_ctrl_monitor
  import led_ctrl_pkg::*;
(
  // All ports of the block
  input wire logic                  REF_CLK, SYS_RST, REG_WR, REG_RD,
  input wire logic [REG_ADDR_W-1:0] REG_ADDR,
  input wire logic [15:0]           REG_WDATA, REG_RDATA,
  input wire logic                  LINK_UP, DUPLEX_FULL, TX_ACTIVE,
  input wire logic                  RX_ACTIVE, COLLISION, DUPLEX_PRESET,
  input wire logic                  DUPLEX_PRESET_VALID, FIRST_LED_IN,
  input wire logic                  FIRST_LED_OUT, FIRST_LED_OE,
  input wire logic                  SECOND_LED_IN, SECOND_LED_OUT,
  input wire logic                  SECOND_LED_OE
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  ////////////////////////////////////////////////////////////////////////
  // Register port
  chk_rdata_idle: assert property (
    !$past(REG_RD) |-> REG_RDATA == 16'h0) else $error("rdata not idle");
  chk_unmapped_read: assert property (
    REG_RD && REG_ADDR != LED_CONTROL_ADDR |=> REG_RDATA == 16'h0)
    else $error("unmapped read not zero");
  chk_reserved_zero: assert property (
    $past(REG_RD) |-> REG_RDATA[15:12] == 4'h0 && !REG_RDATA[0])
    else $error("reserved bits set");
  chk_write_read: assert property (
    REG_WR && REG_ADDR == LED_CONTROL_ADDR ##1
    REG_RD && REG_ADDR == LED_CONTROL_ADDR
    |=> REG_RDATA == ($past(REG_WDATA, 2) & 16'h0ffe))
    else $error("read back differs");
  // Polarity sensing and latching
  chk_sense_quiet: assert property (
    !DUPLEX_PRESET_VALID |-> !FIRST_LED_OUT && !SECOND_LED_OUT
    && !DUPLEX_PRESET) else $error("outputs active while sensing");
  chk_sense_soon: assert property (
    $fell(SYS_RST) |-> ##[1:16] DUPLEX_PRESET_VALID)
    else $error("sensing too slow");
  chk_preset_hold: assert property (
    DUPLEX_PRESET_VALID |=> DUPLEX_PRESET_VALID && $stable(DUPLEX_PRESET))
    else $error("preset changed");
  chk_drive_start: assert property (
    DUPLEX_PRESET_VALID ##1 DUPLEX_PRESET_VALID
    |-> FIRST_LED_OE && SECOND_LED_OE) else $error("pins not driven");
  chk_drive_gate: assert property (
    FIRST_LED_OE || SECOND_LED_OE |-> DUPLEX_PRESET_VALID)
    else $error("pin driven before sensing");
  // Main scenarios
  cover property (REG_WR ##1 REG_RD);
  cover property ($rose(DUPLEX_PRESET_VALID) && DUPLEX_PRESET);
  cover property ($rose(DUPLEX_PRESET_VALID) && !DUPLEX_PRESET);
endmodule
bind phy_led_indicator_control led_ctrl_monitor i_led_ctrl_monitor (.*);

// [testbench/testbench.sv]
// Self-checking bench for the LED indicator block
`timescale 1ns/10ps
module testbench;
  import led_ctrl_pkg::*;
  logic        clk, rst, wr, rd, link, dup, tx, rx, col, pre, pre_ok;
  logic        a_in, a_out, a_oe, b_in, b_out, b_oe;
  logic        a_sink, b_sink, a_lit, b_lit;
  logic [3:0]  addr;
  logic [15:0] wdata, rdata;
  int          fail_count, comparisons, i;
  ////////////////////////////////////////////////////////////////////////
  // Block with short counts, LEDs on both pins
  phy_led_indicator_control #(.NORMAL_CYCLES(20), .MEDIUM_CYCLES(35),
    .LONG_CYCLES(70), .SLOW_CYCLES(16), .FAST_CYCLES(4))
  i_phy_led_indicator_control (.REF_CLK(clk), .SYS_RST(rst),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd),
    .REG_RDATA(rdata), .LINK_UP(link), .DUPLEX_FULL(dup),
    .TX_ACTIVE(tx), .RX_ACTIVE(rx), .COLLISION(col),
    .DUPLEX_PRESET(pre), .DUPLEX_PRESET_VALID(pre_ok),
    .FIRST_LED_IN(a_in), .FIRST_LED_OUT(a_out), .FIRST_LED_OE(a_oe),
    .SECOND_LED_IN(b_in), .SECOND_LED_OUT(b_out), .SECOND_LED_OE(b_oe));
  led_partner i_led_partner (.drive(a_out), .oe(a_oe), .sink(a_sink),
    .pin(a_in), .lit(a_lit));
  led_partner i_led_partner_b (.drive(b_out), .oe(b_oe), .sink(b_sink),
    .pin(b_in), .lit(b_lit));
  // Clock
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp16({15'h0, got}, {15'h0, exp});
  endtask
  task automatic give_verdict();
    $display("Mismatches %0d in %0d comparisons", fail_count, comparisons);
    if (fail_count == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic reg_read(input logic [3:0] a, input logic [15:0] exp);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp16(rdata, exp);
  endtask
  task automatic do_reset(input logic sa, input logic sb, input logic e);
    @(posedge clk);
    rst <= 1'b1;
    a_sink <= sa;
    b_sink <= sb;
    cyc(16);
    rst <= 1'b0;
    for (i = 0; i < 40 && pre_ok !== 1'b1; i++) @(negedge clk);
    cmp1(pre_ok, 1'b1);
    if (pre_ok !== 1'b1) give_verdict();
    cyc(2);
    @(negedge clk);
    cmp1(pre, e);
  endtask
  task automatic t_regs();
    reg_read(LED_CONTROL_ADDR, 16'h0422);
    reg_read(4'h5, 16'h0);
    reg_write(LED_CONTROL_ADDR, 16'hf877);
    reg_write(4'h3, 16'h0000);
    reg_read(LED_CONTROL_ADDR, 16'h0876);
    @(posedge clk);
    wdata <= 16'h0a56;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    cmp16(rdata, 16'h0a56);
  endtask
  task automatic t_codes();
    logic [3:0] c [4];
    logic       e [4];
    c = '{CFG_ON, CFG_OFF, CFG_LINK, CFG_DUPLEX};
    e = '{1'b1, 1'b0, 1'b1, 1'b0};
    @(posedge clk);
    link <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      reg_write(LED_CONTROL_ADDR, {4'h0, c[k], c[k], 4'h2});
      cyc(3);
      @(negedge clk);
      cmp1(a_lit, e[k]);
      cmp1(b_lit, e[k]);
    end
    // Duplex code follows the duplex status input
    @(posedge clk);
    dup <= 1'b1;
    cyc(3);
    @(negedge clk);
    cmp1(a_lit, 1'b1);
    cmp1(b_lit, 1'b1);
    @(posedge clk);
    dup <= 1'b0;
  endtask
  // Slow blink on the first pin, fast blink on the second
  task automatic t_blink();
    logic x;
    logic y;
    reg_write(LED_CONTROL_ADDR, 16'h0ba2);
    cyc(3);
    @(negedge clk);
    x = a_lit;
    y = b_lit;
    cyc(4);
    @(negedge clk);
    cmp1(b_lit ^ y, 1'b1);
    cyc(12);
    @(negedge clk);
    cmp1(a_lit ^ x, 1'b1);
    cmp1(b_lit ^ y, 1'b0);
  endtask
  task automatic t_wiring();
    reg_write(LED_CONTROL_ADDR, 16'h0892);
    @(posedge clk);
    a_sink <= 1'b1;
    cyc(4);
    @(negedge clk);
    cmp1(a_out, 1'b1);
    @(posedge clk);
    a_sink <= 1'b0;
  endtask
  // One activity pulse, then the first LED is judged after dly cycles
  task automatic t_event(input logic [15:0] v, input int src,
                         input int dly, input logic e);
    reg_write(LED_CONTROL_ADDR, v);
    @(posedge clk);
    rx <= (src == 0);
    tx <= (src == 1);
    col <= (src == 2);
    @(posedge clk);
    {rx, tx, col} <= 3'h0;
    cyc(dly);
    @(negedge clk);
    cmp1(a_lit, e);
  endtask
  task automatic t_stretch();
    @(posedge clk);
    link <= 1'b0;
    t_event(16'h0292, 0, 10, 1'b1);
    t_event(16'h0292, 0, 25, 1'b0);
    t_event(16'h0296, 0, 30, 1'b1);
    t_event(16'h029a, 0, 60, 1'b1);
    t_event(16'h0290, 0, 4, 1'b0);
    t_event(16'h0c90, 0, 10, 1'b1);
    t_event(16'h0d90, 1, 10, 1'b1);
    t_event(16'h0e90, 2, 10, 1'b1);
    t_event(16'h0792, 1, 10, 1'b1);
    t_event(16'h0392, 2, 10, 1'b1);
    t_event(16'h0192, 1, 10, 1'b1);
    t_event(16'h0790, 1, 4, 1'b0);
    t_event(16'h0390, 2, 4, 1'b0);
  endtask
  task automatic t_sinking();
    @(posedge clk);
    link <= 1'b1;
    cyc(3);
    @(negedge clk);
    cmp1(a_lit, 1'b1);
    cmp1(a_out, 1'b0);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rst = 1'b1;
    {wr, rd, link, dup, tx, rx, col} = 7'h0;
    addr = 4'h0;
    wdata = 16'h0;
    a_sink = 1'b0;
    b_sink = 1'b1;
    fail_count = 0;
    comparisons = 0;
    do_reset(1'b0, 1'b1, 1'b1);
    t_regs();
    t_codes();
    t_blink();
    t_wiring();
    t_stretch();
    do_reset(1'b1, 1'b0, 1'b0);
    t_sinking();
    give_verdict();
  end
endmodule
